/* log_page_unit.sv */
// changed-namespace and command-effects log pages behind an axi4-lite slave
// assumes a single clock; namespace change events arrive as one-cycle pulses
// What the document asks of this block and of its host
// RULE_01: log id 04h selects the changed-namespace list.
// RULE_02: list holds up to 1024 namespaces changed since last read.
// RULE_03: over 1024 changes: first entry 0FFFFFFFh, rest zero.
// RULE_04: reading the last list word clears the change record.
// RULE_05: log id 05h gives 4096-byte effects page; bytes 2048-4095 reserved.
// RULE_06: words 0-255 are admin opcode descriptors.
// RULE_07: words 256-511 are i/o opcode descriptors.
// RULE_08: i/o descriptors follow the selected command set.
// RULE_09: restriction code in bits 18:16; reserved codes and bits zero.
// RULE_10: host keeps code 001b commands alone per namespace.
// RULE_11: host keeps code 010b commands alone on whole controller.
// RULE_12: bit 4 flags possible controller capability change.
// RULE_13: host re-initialises a capability after a changing command.
// RULE_14: host pauses namespace, waits, re-identifies around capability change.
// RULE_15: bit 0 flags supported; unsupported descriptor is all zero.
// RULE_16: bits 1, 2, 3 flag content, namespace and inventory change.
// RULE_17: reserved bytes and bits read as zero.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
module log_page_unit
  import log_page_pkg::*;
(
  input  wire logic                      i_mclk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_ns_change,
  input  wire logic [31:0]               i_ns_change_id,
  input  wire logic                      i_awvalid,
  output      logic                      o_awready,
  input  wire logic [log_page_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                      i_wvalid,
  output      logic                      o_wready,
  input  wire logic [31:0]               i_wdata,
  input  wire logic [3:0]                i_wstrb,
  output      logic                      o_bvalid,
  input  wire logic                      i_bready,
  output      logic [1:0]                o_bresp,
  input  wire logic                      i_arvalid,
  output      logic                      o_arready,
  input  wire logic [log_page_pkg::ADDR_W-1:0] i_araddr,
  output      logic                      o_rvalid,
  input  wire logic                      i_rready,
  output      logic [31:0]               o_rdata,
  output      logic [1:0]                o_rresp
);
  import log_page_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]       ns_list_q [NS_LIST_DEPTH];
  logic [10:0]       ns_cnt_q;
  logic              ns_ovf_q;
  logic [7:0]        log_id_q;
  logic [IDX_W-1:0]  page_idx_q;
  logic [2:0]        css_q;
  desc_sel_t         desc_sel_q;
  logic              awready_q, wready_q, bvalid_q, arready_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q, wdata_q;
  logic [3:0]        wstrb_q;
  logic [ADDR_W-1:0] awaddr_q;
  rd_state_t         rd_state_q;
  logic              pg_rd_q;
  logic [IDX_W-1:0]  pg_idx_q;
  logic [7:0]        pg_log_q;
  logic              pg_ovf_q;
  effect_desc_t      desc_rd;
  desc_sel_t         tbl_sel;
  logic              wr_go, ar_go, page_rd, list_clear, desc_wr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == OFS_LOG_ID || a == OFS_PAGE_INDEX || a == OFS_PAGE_DATA ||
           a == OFS_STATUS || a == OFS_CONFIG || a == OFS_DESC_SEL || a == OFS_DESC_DATA;
  endfunction

  // ----------------------------------------------------------------
  // page word lookup
  // ----------------------------------------------------------------
  always_comb begin
    tbl_sel.io     = page_rd ? (page_idx_q >= IO_BASE_IDX) : desc_sel_q.io;
    tbl_sel.opcode = page_rd ? page_idx_q[7:0] : desc_sel_q.opcode;     // RULE_06 RULE_07
  end

  function automatic logic [31:0] page_word(input logic [IDX_W-1:0] idx,
                                            input effect_desc_t d);
    logic [31:0] w;
    w = '0;
    if (log_id_q == LOG_ID_CHANGED_NS) begin                          // RULE_01
      if (ns_ovf_q) begin
        w = (idx == IDX_FIRST) ? NS_OVERFLOW_MARK : '0;               // RULE_03
      end else if ({1'b0, idx} < ns_cnt_q) begin
        w = ns_list_q[idx];                                           // RULE_02
      end
    end else if (log_id_q == LOG_ID_CMD_EFFECTS) begin                // RULE_05
      if (idx < IO_BASE_IDX) begin
        w = d;                                                        // RULE_06 RULE_12 RULE_16
      end else if (idx < RSVD_BASE_IDX && css_q == CSS_NVM) begin
        w = d;                                                        // RULE_07 RULE_08
      end
    end
    return w;                                                         // RULE_17
  endfunction

  effect_table u_table (
    .i_mclk    (i_mclk),
    .i_resetn  (i_resetn),
    .i_wr_en   (desc_wr),
    .i_wr_sel  (desc_sel_q),
    .i_wr_data (effect_desc_t'(wdata_q)),
    .i_rd_sel  (tbl_sel),
    .o_rd_data (desc_rd)
  );

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  assign wr_go   = !awready_q && !wready_q && !bvalid_q;
  assign ar_go   = i_arvalid && arready_q;
  assign page_rd = ar_go && i_araddr == OFS_PAGE_DATA;
  assign desc_wr = wr_go && awaddr_q == OFS_DESC_DATA;
  assign list_clear = page_rd && log_id_q == LOG_ID_CHANGED_NS && page_idx_q == IDX_LAST;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (i_awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q  <= i_awaddr;
      end
      if (i_wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && i_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      log_id_q   <= '0;
      css_q      <= CSS_NVM;
      desc_sel_q <= '0;
    end else if (wr_go) begin
      case (awaddr_q)
        OFS_LOG_ID:   log_id_q   <= 8'(merge({24'h0, log_id_q}, wdata_q, wstrb_q));
        OFS_CONFIG:   css_q      <= 3'(merge({29'h0, css_q}, wdata_q, wstrb_q));
        OFS_DESC_SEL: desc_sel_q <= desc_sel_t'(9'(merge({23'h0, desc_sel_q}, wdata_q,
                                                         wstrb_q)));
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      page_idx_q <= IDX_FIRST;
    end else if (wr_go && awaddr_q == OFS_PAGE_INDEX) begin
      page_idx_q <= IDX_W'(merge({22'h0, page_idx_q}, wdata_q, wstrb_q));
    end else if (page_rd) begin
      page_idx_q <= page_idx_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // changed namespace record
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ns_cnt_q <= '0;
      ns_ovf_q <= 1'b0;
    end else if (list_clear) begin
      ns_cnt_q <= i_ns_change ? 11'h001 : 11'h000;                    // RULE_04
      ns_ovf_q <= 1'b0;                                               // RULE_04
    end else if (i_ns_change) begin
      if (ns_cnt_q == NS_LIST_FULL) begin
        ns_ovf_q <= 1'b1;                                             // RULE_03
      end else begin
        ns_cnt_q <= ns_cnt_q + 11'h001;                               // RULE_02
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_ns_change) begin
      if (list_clear) begin
        ns_list_q[0] <= i_ns_change_id;
      end else if (ns_cnt_q != NS_LIST_FULL) begin
        ns_list_q[ns_cnt_q[IDX_W-1:0]] <= i_ns_change_id;             // RULE_02
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_state_q <= RD_IDLE;
      arready_q  <= 1'b1;
      rdata_q    <= '0;
      rresp_q    <= RESP_OKAY;
      pg_rd_q    <= 1'b0;
      pg_idx_q   <= '0;
      pg_log_q   <= '0;
      pg_ovf_q   <= 1'b0;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          if (ar_go) begin
            rd_state_q <= RD_RESP;
            arready_q  <= 1'b0;
            pg_rd_q    <= page_rd;
            pg_idx_q   <= page_idx_q;
            pg_log_q   <= log_id_q;
            pg_ovf_q   <= ns_ovf_q;
            rresp_q    <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (i_araddr)
              OFS_LOG_ID:     rdata_q <= {24'h0, log_id_q};
              OFS_PAGE_INDEX: rdata_q <= {22'h0, page_idx_q};
              OFS_PAGE_DATA:  rdata_q <= page_word(page_idx_q, desc_rd);
              OFS_STATUS:     rdata_q <= {15'h0, ns_ovf_q, 5'h0, ns_cnt_q};
              OFS_CONFIG:     rdata_q <= {29'h0, css_q};
              OFS_DESC_SEL:   rdata_q <= {23'h0, desc_sel_q};
              OFS_DESC_DATA:  rdata_q <= desc_rd;
              default:        rdata_q <= '0;
            endcase
          end
        end
        RD_RESP: begin
          if (i_rready) begin
            rd_state_q <= RD_IDLE;
            arready_q  <= 1'b1;
            pg_rd_q    <= 1'b0;
          end
        end
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end

  assign o_awready = awready_q;
  assign o_wready  = wready_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid  = rd_state_q == RD_RESP;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  sequence s_list_read;
    o_rvalid && pg_rd_q && pg_log_q == LOG_ID_CHANGED_NS;
  endsequence
  sequence s_fx_read;
    o_rvalid && pg_rd_q && pg_log_q == LOG_ID_CMD_EFFECTS;
  endsequence
  sequence s_both_taken;
    !o_awready && !o_wready && !o_bvalid;
  endsequence

  chk_overflow_mark: assert property (s_list_read and ##0 (pg_ovf_q && pg_idx_q == IDX_FIRST)
    |-> o_rdata == NS_OVERFLOW_MARK) else $error("overflow mark missing"); // RULE_03
  chk_overflow_fill: assert property (s_list_read and ##0 (pg_ovf_q && pg_idx_q != IDX_FIRST)
    |-> o_rdata == 32'h0) else $error("overflow fill not zero"); // RULE_03
  chk_list_clear: assert property (list_clear && !i_ns_change |=> ns_cnt_q == 11'h000 && !ns_ovf_q)
    else $error("record not cleared after last word"); // RULE_04
  chk_rsvd_tail: assert property (s_fx_read and ##0 (pg_idx_q >= RSVD_BASE_IDX)
    |-> o_rdata == 32'h0) else $error("reserved page bytes not zero"); // RULE_05
  chk_unsupp_zero: assert property (s_fx_read and ##0 !o_rdata[0] |-> o_rdata == 32'h0)
    else $error("unsupported descriptor not zero"); // RULE_15
  chk_desc_rsvd: assert property (s_fx_read |-> o_rdata[31:19] == 13'h0 &&
    o_rdata[15:5] == 11'h0 && o_rdata[18:16] <= CSE_ALL_NS) else $error("descriptor reserved bits"); // RULE_09
  chk_io_css: assert property (s_fx_read and ##0 (pg_idx_q >= IO_BASE_IDX && css_q != CSS_NVM)
    |-> o_rdata == 32'h0) else $error("io descriptor ignores command set"); // RULE_08
  chk_cnt_grow: assert property (i_ns_change && !list_clear && ns_cnt_q < NS_LIST_FULL
    |=> ns_cnt_q == $past(ns_cnt_q) + 11'h001) else $error("change not recorded"); // RULE_02
  chk_bresp_time: assert property (s_both_taken |-> ##1 o_bvalid)
    else $error("write response late");
  chk_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data not held");

endmodule // log_page_unit

/* log_page_pkg.sv */
// constants, types and register map shared by the log page block
// assumes a single 50 MHz controller core clock domain
package log_page_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the 32-bit bus)
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_LOG_ID      = 8'h00;
  localparam logic [7:0]  OFS_PAGE_INDEX  = 8'h04;
  localparam logic [7:0]  OFS_PAGE_DATA   = 8'h08;
  localparam logic [7:0]  OFS_STATUS      = 8'h0c;
  localparam logic [7:0]  OFS_CONFIG      = 8'h10;
  localparam logic [7:0]  OFS_DESC_SEL    = 8'h14;
  localparam logic [7:0]  OFS_DESC_DATA   = 8'h18;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------
  // log pages
  // ----------------------------------------------------------------
  localparam logic [7:0]  LOG_ID_CHANGED_NS  = 8'h04;
  localparam logic [7:0]  LOG_ID_CMD_EFFECTS = 8'h05;
  localparam int          NS_LIST_DEPTH      = 1024;
  localparam logic [10:0] NS_LIST_FULL       = 11'h400;
  localparam logic [31:0] NS_OVERFLOW_MARK   = 32'h0fffffff;
  localparam int          IDX_W              = 10;
  localparam logic [9:0]  IDX_LAST           = 10'h3ff;
  localparam logic [9:0]  IDX_FIRST          = 10'h000;
  localparam logic [9:0]  IO_BASE_IDX        = 10'h100;
  localparam logic [9:0]  RSVD_BASE_IDX      = 10'h200;

  // ----------------------------------------------------------------
  // effect descriptor
  // ----------------------------------------------------------------
  localparam logic [2:0]  CSE_NONE     = 3'h0;
  localparam logic [2:0]  CSE_SAME_NS  = 3'h1;
  localparam logic [2:0]  CSE_ALL_NS   = 3'h2;
  localparam logic [2:0]  CSS_NVM      = 3'h0;
  localparam int          DESC_SEL_IO  = 8;

  typedef struct packed {
    logic [12:0] rsvd_hi;
    logic [2:0]  submission_restriction_code;
    logic [10:0] rsvd_lo;
    logic        controller_capability_change_flag;
    logic        namespace_inventory_change_flag;
    logic        namespace_capability_change_flag;
    logic        block_content_change_flag;
    logic        command_supported_flag;
  } effect_desc_t;

  typedef struct packed {
    logic       io;
    logic [7:0] opcode;
  } desc_sel_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_t;

endpackage

/* effect_table.sv */
// command effect descriptor store, one word per admin and per i/o opcode
// assumes writes come from the register slave of the log page block
module effect_table
  import log_page_pkg::*;
(
  input  wire logic                       i_mclk,
  input  wire logic                       i_resetn,
  input  wire logic                       i_wr_en,
  input  wire log_page_pkg::desc_sel_t    i_wr_sel,
  input  wire log_page_pkg::effect_desc_t i_wr_data,
  input  wire log_page_pkg::desc_sel_t    i_rd_sel,
  output      log_page_pkg::effect_desc_t o_rd_data
);
  import log_page_pkg::*;

  effect_desc_t admin_q [256];
  effect_desc_t io_q    [256];
  effect_desc_t clean_d;

  // ----------------------------------------------------------------
  // sanitise on write
  // ----------------------------------------------------------------
  always_comb begin
    clean_d = i_wr_data;
    clean_d.rsvd_hi = '0;                                          // RULE_17
    clean_d.rsvd_lo = '0;                                          // RULE_09
    if (i_wr_data.submission_restriction_code > CSE_ALL_NS) begin
      clean_d.submission_restriction_code = CSE_NONE;              // RULE_09
    end
    if (!i_wr_data.command_supported_flag) begin
      clean_d = '0;                                                // RULE_15
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < 256; i++) begin
        admin_q[i] <= '0;
        io_q[i]    <= '0;
      end
    end else if (i_wr_en) begin
      if (i_wr_sel.io) begin
        io_q[i_wr_sel.opcode] <= clean_d;
      end else begin
        admin_q[i_wr_sel.opcode] <= clean_d;
      end
    end
  end

  assign o_rd_data = i_rd_sel.io ? io_q[i_rd_sel.opcode] : admin_q[i_rd_sel.opcode];

endmodule // effect_table

/* host_bus_model.sv */
// host side register bus master for the log page block
// assumes the bench calls its tasks one at a time
module host_bus_model
  import log_page_pkg::*;
(
  input  wire logic                            i_mclk,
  output      logic                            o_awvalid,
  output      logic [log_page_pkg::ADDR_W-1:0] o_awaddr,
  output      logic                            o_wvalid,
  output      logic [31:0]                     o_wdata,
  output      logic [3:0]                      o_wstrb,
  output      logic                            o_bready,
  output      logic                            o_arvalid,
  output      logic [log_page_pkg::ADDR_W-1:0] o_araddr,
  output      logic                            o_rready,
  input  wire logic                            i_awready,
  input  wire logic                            i_wready,
  input  wire logic                            i_bvalid,
  input  wire logic [1:0]                      i_bresp,
  input  wire logic                            i_arready,
  input  wire logic                            i_rvalid,
  input  wire logic [31:0]                     i_rdata,
  input  wire logic [1:0]                      i_rresp
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_awvalid = 1'b0;
    o_awaddr  = 8'h00;
    o_wvalid  = 1'b0;
    o_wdata   = 32'h0;
    o_wstrb   = 4'hf;
    o_bready  = 1'b0;
    o_arvalid = 1'b0;
    o_araddr  = 8'h00;
    o_rready  = 1'b0;
  end

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge i_mclk);
    o_awvalid <= 1'b1;
    o_awaddr  <= a;
    o_wvalid  <= 1'b1;
    o_wdata   <= d;
    o_bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge i_mclk);
      if (!aw_ok && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
        aw_ok = 1'b1;
      end
      if (!w_ok && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata  <= ~d;
        w_ok = 1'b1;
      end
    end
    // nothing new is issued until this one completes
    do @(posedge i_mclk); while (!i_bvalid);
    r = i_bresp;
    o_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_mclk);
    o_arvalid <= 1'b1;
    o_araddr  <= a;
    o_rready  <= 1'b1;
    do @(posedge i_mclk); while (!i_arready);
    o_arvalid <= 1'b0;
    o_araddr  <= ~a;
    do @(posedge i_mclk); while (!i_rvalid);
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
  endtask
endmodule // host_bus_model

/* test_changed_ns_and_cmd_effects_log.sv */
// self-checking bench for the log page block
// assumes the host bus model drives the register bus
module test_changed_ns_and_cmd_effects_log;
  import log_page_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] exp;
    logic [1:0]  resp;
  } row_t;

  logic        i_mclk;
  logic        i_resetn;
  logic        ns_chg;
  logic [31:0] ns_id;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          err_total;
  int          checked;
  row_t        rows [9];

  log_page_unit i_log_page_unit (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ns_change(ns_chg), .i_ns_change_id(ns_id),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp)
  );

  host_bus_model i_host_bus_model (
    .i_mclk(i_mclk), .o_awvalid(awvalid), .o_awaddr(awaddr), .o_wvalid(wvalid),
    .o_wdata(wdata), .o_wstrb(wstrb), .o_bready(bready), .o_arvalid(arvalid),
    .o_araddr(araddr), .o_rready(rready), .i_awready(awready), .i_wready(wready),
    .i_bvalid(bvalid), .i_bresp(bresp), .i_arready(arready), .i_rvalid(rvalid),
    .i_rdata(rdata), .i_rresp(rresp)
  );

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    i_host_bus_model.wr(a, v, rs);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    i_host_bus_model.rd(a, v, rs);
    chk(v, e);
  endtask

  task automatic pg(input logic [9:0] i, input logic [31:0] e);
    w(OFS_PAGE_INDEX, {22'h0, i});
    rc(OFS_PAGE_DATA, e);
  endtask

  // one change event per high cycle, ids counting up from base
  task automatic ev(input int n, input logic [31:0] base);
    for (int k = 0; k < n; k++) begin
      @(posedge i_mclk);
      ns_chg <= 1'b1;
      ns_id  <= base + 32'(k);
    end
    @(posedge i_mclk);
    ns_chg <= 1'b0;
    ns_id  <= ~ns_id;
  endtask

  initial begin
    repeat (30000) @(posedge i_mclk);
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    i_resetn  = 1'b0;
    ns_chg    = 1'b0;
    ns_id     = 32'h0;
    err_total = 0;
    checked   = 0;
    rows = '{
      '{OFS_DESC_SEL, 32'h005, OFS_DESC_SEL, 32'h005, RESP_OKAY},
      '{OFS_DESC_DATA, 32'h0002001f, OFS_DESC_DATA, 32'h0002001f, RESP_OKAY},
      '{OFS_DESC_DATA, 32'h0007001f, OFS_DESC_DATA, 32'h0000001f, RESP_OKAY},
      '{OFS_DESC_DATA, 32'hfff8ffe6, OFS_DESC_DATA, 32'h0, RESP_OKAY},
      '{OFS_DESC_DATA, 32'hfff9ffff, OFS_DESC_DATA, 32'h0001001f, RESP_OKAY},
      '{OFS_CONFIG, 32'h2, OFS_CONFIG, 32'h2, RESP_OKAY},
      '{OFS_CONFIG, 32'h0, OFS_CONFIG, 32'h0, RESP_OKAY},
      '{OFS_STATUS, 32'hffff, OFS_STATUS, 32'h0, RESP_OKAY},
      '{8'h1c, 32'h1, 8'h1c, 32'h0, RESP_SLVERR}
    };
    repeat (5) @(posedge i_mclk);
    i_resetn <= 1'b1;
    foreach (rows[k]) begin
      i_host_bus_model.wr(rows[k].wa, rows[k].wd, r);
      chk({30'h0, r}, {30'h0, rows[k].resp});
      i_host_bus_model.rd(rows[k].ra, d, r);
      chk(d, rows[k].exp);
      chk({30'h0, r}, {30'h0, rows[k].resp});
    end
    // effects page layout
    w(OFS_DESC_SEL, 32'h0ff);
    w(OFS_DESC_DATA, 32'h00020013);
    w(OFS_DESC_SEL, 32'h100);
    w(OFS_DESC_DATA, 32'h0001000f);
    w(OFS_DESC_SEL, 32'h1ff);
    w(OFS_DESC_DATA, 32'h00000003);
    w(OFS_LOG_ID, {24'h0, LOG_ID_CMD_EFFECTS});
    pg(10'h005, 32'h0001001f);
    pg(10'h0ff, 32'h00020013);
    rc(OFS_PAGE_DATA, 32'h0001000f);
    pg(10'h1ff, 32'h00000003);
    rc(OFS_PAGE_DATA, 32'h0);
    w(OFS_CONFIG, 32'h1);
    pg(10'h100, 32'h0);
    w(OFS_CONFIG, 32'h0);
    pg(10'h100, 32'h0001000f);
    w(OFS_LOG_ID, 32'h06);
    pg(10'h0ff, 32'h0);
    // changed-namespace list, small, full and overflowed
    w(OFS_LOG_ID, {24'h0, LOG_ID_CHANGED_NS});
    ev(3, 32'h10);
    rc(OFS_STATUS, 32'h3);
    pg(10'h000, 32'h10);
    rc(OFS_PAGE_DATA, 32'h11);
    rc(OFS_PAGE_DATA, 32'h12);
    rc(OFS_PAGE_DATA, 32'h0);
    pg(IDX_LAST, 32'h0);
    rc(OFS_STATUS, 32'h0);
    ev(NS_LIST_DEPTH, 32'h1000);
    rc(OFS_STATUS, 32'h400);
    pg(IDX_LAST, 32'h13ff);
    rc(OFS_STATUS, 32'h0);
    ev(NS_LIST_DEPTH + 1, 32'h2000);
    i_host_bus_model.rd(OFS_STATUS, d, r);
    chk({31'h0, d[16]}, 32'h1);
    pg(IDX_FIRST, NS_OVERFLOW_MARK);
    rc(OFS_PAGE_DATA, 32'h0);
    pg(IDX_LAST, 32'h0);
    rc(OFS_STATUS, 32'h0);
    // reset in mid-run clears list, registers and descriptors
    ev(2, 32'h30);
    @(posedge i_mclk);
    i_resetn <= 1'b0;
    repeat (5) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rc(OFS_STATUS, 32'h0);
    rc(OFS_LOG_ID, 32'h0);
    rc(OFS_DESC_SEL, 32'h0);
    w(OFS_DESC_SEL, 32'h005);
    rc(OFS_DESC_DATA, 32'h0);
    end_of_test();
  end
endmodule // test_changed_ns_and_cmd_effects_log
